// [include/dmac_pkg.sv]
package dmac_pkg;

    localparam int OP_W   = 36;
    localparam int PROD_W = 72;
    localparam int ACC_W  = 72;
    localparam int SRC_N  = 4;
    localparam int SEL_W  = 2;

    localparam logic [OP_W-1:0]   OP_RESET   = 36'h0_0000_0000;
    localparam logic [PROD_W-1:0] PROD_RESET = 72'h00_0000_0000_0000_0000;
    localparam logic [ACC_W-1:0]  ACC_RESET  = 72'h00_0000_0000_0000_0000;

    // native multiplier widths
    typedef enum logic [1:0] {
        DMAC_W9,
        DMAC_W18,
        DMAC_W36
    } dmac_width_t;

    // enable and reset source choice for one register stage
    typedef struct packed {
        logic [SEL_W-1:0] ceSel;
        logic [SEL_W-1:0] rstSel;
    } dmac_stage_cfg_t;

    typedef struct packed {
        logic [OP_W-1:0]   aReg;
        logic [OP_W-1:0]   bReg;
        logic              inSigned;
        logic [PROD_W-1:0] prodReg;
        logic              pipeSigned;
        logic [ACC_W-1:0]  accReg;
        logic              overflowReg;
    } dmac_state_t;

    // pads an operand to the full input width from the selected native width
    function automatic logic [OP_W-1:0] dmacExtend(input logic [OP_W-1:0] v,
                                                   input dmac_width_t      w,
                                                   input logic             sgn);
        logic [OP_W-1:0] r;
        r = v;
        case (w)
            DMAC_W9:  r = {{27{sgn & v[8]}}, v[8:0]};
            DMAC_W18: r = {{18{sgn & v[17]}}, v[17:0]};
            DMAC_W36: r = v;
            default:  r = v;
        endcase
        return r;
    endfunction : dmacExtend

endpackage : dmac_pkg

// [hw/dmac_src_sel.sv]
`timescale 1ns/1ps
`default_nettype none

module dmac_src_sel
    import dmac_pkg::*;
(
    // shared pools
    input  wire logic [SRC_N-1:0]  ceSrc,
    input  wire logic [SRC_N-1:0]  rstSrc,
    // stage choice
    input  wire dmac_stage_cfg_t   cfg,
    // selected controls
    output logic                   ce,
    output logic                   rst
);

    assign ce  = ceSrc[cfg.ceSel];
    assign rst = rstSrc[cfg.rstSel];

endmodule : dmac_src_sel

`default_nettype wire

// [hw/dmac_multiply_accumulate.sv]
// Function
// - each register stage selects enable and reset
// - signed or unsigned multiply at 9/18/36
// - unsigned overflow when result below previous
// - signed overflow on same-sign wrong-sign sum
// - overflow is held for one cycle per overflowing accumulate
`timescale 1ns/1ps
`default_nettype none

module dmac_multiply_accumulate
    import dmac_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset,
    // enable and reset pools
    input  wire logic              clkEnableSource0,
    input  wire logic              clkEnableSource1,
    input  wire logic              clkEnableSource2,
    input  wire logic              clkEnableSource3,
    input  wire logic              resetSource0,
    input  wire logic              resetSource1,
    input  wire logic              resetSource2,
    input  wire logic              resetSource3,
    // per-stage selection
    input  wire dmac_stage_cfg_t   inCfg,
    input  wire dmac_stage_cfg_t   pipeCfg,
    input  wire dmac_stage_cfg_t   outCfg,
    // operands and mode
    input  wire logic [OP_W-1:0]   opA,
    input  wire logic [OP_W-1:0]   opB,
    input  wire dmac_width_t       opWidth,
    input  wire logic              opSigned,
    // results
    output logic [ACC_W-1:0]       accOut,
    output logic                   overflow
);

    logic [SRC_N-1:0] ceSrc;
    logic [SRC_N-1:0] rstSrc;
    logic             inCe;
    logic             inRst;
    logic             pipeCe;
    logic             pipeRst;
    logic             outCe;
    logic             outRst;
    dmac_state_t      st_reg;
    dmac_state_t      st_next;
    logic [ACC_W-1:0] sum;
    logic             ovfUnsigned;
    logic             ovfSigned;
    logic             ovfEvent;
    logic [PROD_W-1:0] prodNow;

    assign ceSrc  = {clkEnableSource3, clkEnableSource2, clkEnableSource1, clkEnableSource0};
    assign rstSrc = {resetSource3, resetSource2, resetSource1, resetSource0};

    // one selector per stage, all sharing the same pools
    dmac_src_sel uInSel (
        .ceSrc  (ceSrc),
        .rstSrc (rstSrc),
        .cfg    (inCfg),
        .ce     (inCe),
        .rst    (inRst)
    );

    dmac_src_sel uPipeSel (
        .ceSrc  (ceSrc),
        .rstSrc (rstSrc),
        .cfg    (pipeCfg),
        .ce     (pipeCe),
        .rst    (pipeRst)
    );

    dmac_src_sel uOutSel (
        .ceSrc  (ceSrc),
        .rstSrc (rstSrc),
        .cfg    (outCfg),
        .ce     (outCe),
        .rst    (outRst)
    );

    // full-width product; sign follows the mode captured with the operands
    always_comb begin
        if (st_reg.inSigned) begin
            prodNow = PROD_W'($signed(st_reg.aReg) * $signed(st_reg.bReg));
        end else begin
            prodNow = PROD_W'(st_reg.aReg * st_reg.bReg);
        end
    end

    // carry out is dropped on purpose; roll-over is reported by the flag
    assign sum         = ACC_W'(st_reg.accReg + st_reg.prodReg);
    assign ovfUnsigned = (sum < st_reg.accReg);
    assign ovfSigned   = (st_reg.accReg[ACC_W-1] == st_reg.prodReg[PROD_W-1])
                       && (sum[ACC_W-1] != st_reg.accReg[ACC_W-1]);
    assign ovfEvent    = st_reg.pipeSigned ? ovfSigned : ovfUnsigned;

    always_comb begin
        st_next = st_reg;
        // input stage: reset beats enable, as in every stage
        if (inRst) begin
            st_next.aReg     = OP_RESET;
            st_next.bReg     = OP_RESET;
            st_next.inSigned = 1'b0;
        end else if (inCe) begin
            // upper bits above the native width are replaced, not trusted
            st_next.aReg     = dmacExtend(opA, opWidth, opSigned);
            st_next.bReg     = dmacExtend(opB, opWidth, opSigned);
            st_next.inSigned = opSigned;
        end
        if (pipeRst) begin
            st_next.prodReg    = PROD_RESET;
            st_next.pipeSigned = 1'b0;
        end else if (pipeCe) begin
            st_next.prodReg    = prodNow;
            st_next.pipeSigned = st_reg.inSigned;
        end
        // flag drops on any cycle without a fresh accumulate
        st_next.overflowReg = 1'b0;
        if (outRst) begin
            st_next.accReg = ACC_RESET;
        end else if (outCe) begin
            st_next.accReg      = sum;
            st_next.overflowReg = ovfEvent;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign accOut   = st_reg.accReg;
    assign overflow = st_reg.overflowReg;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_in_capture;
        inCe && !inRst |=> st_reg.aReg == dmacExtend($past(opA), $past(opWidth), $past(opSigned));
    endproperty
    a_in_capture: assert property (p_in_capture) else $error("operand not padded on capture");

    property p_in_hold;
        !inCe && !inRst |=> $stable(st_reg.aReg) && $stable(st_reg.bReg);
    endproperty
    a_in_hold: assert property (p_in_hold) else $error("input stage moved without enable");

    property p_pipe_clear;
        pipeRst |=> st_reg.prodReg == PROD_RESET;
    endproperty
    a_pipe_clear: assert property (p_pipe_clear) else $error("pipeline not cleared by its reset");

    sequence s_accumulate;
        outCe && !outRst;
    endsequence

    property p_acc_add;
        s_accumulate |=> accOut == ACC_W'($past(st_reg.accReg) + $past(st_reg.prodReg));
    endproperty
    a_acc_add: assert property (p_acc_add) else $error("accumulator did not add product");

    property p_acc_clear;
        outRst |=> accOut == ACC_RESET && !overflow;
    endproperty
    a_acc_clear: assert property (p_acc_clear) else $error("accumulator not cleared");

    sequence s_unsigned_wrap;
        s_accumulate ##0 !st_reg.pipeSigned ##0 (sum < st_reg.accReg);
    endsequence

    property p_ovf_unsigned;
        s_unsigned_wrap |=> overflow && accOut < $past(accOut);
    endproperty
    a_ovf_unsigned: assert property (p_ovf_unsigned) else $error("unsigned roll-over missed");

    sequence s_signed_wrap;
        s_accumulate ##0 st_reg.pipeSigned
            ##0 (st_reg.accReg[ACC_W-1] == st_reg.prodReg[PROD_W-1])
            ##0 (sum[ACC_W-1] != st_reg.accReg[ACC_W-1]);
    endsequence

    property p_ovf_signed;
        s_signed_wrap |=> overflow;
    endproperty
    a_ovf_signed: assert property (p_ovf_signed) else $error("signed overflow missed");

    property p_ovf_pulse;
        overflow && !(outCe && !outRst) |=> !overflow;
    endproperty
    a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow held past one cycle");

    property p_ovf_cause;
        overflow |-> $past(outCe) && !$past(outRst);
    endproperty
    a_ovf_cause: assert property (p_ovf_cause) else $error("overflow without an accumulate");

    property p_in_clear;
        inRst |=> st_reg.aReg == OP_RESET && st_reg.bReg == OP_RESET && !st_reg.inSigned;
    endproperty
    a_in_clear: assert property (p_in_clear) else $error("input stage not cleared by its reset");

    property p_pipe_hold;
        !pipeCe && !pipeRst |=> $stable(st_reg.prodReg) && $stable(st_reg.pipeSigned);
    endproperty
    a_pipe_hold: assert property (p_pipe_hold) else $error("pipeline moved without enable");

    property p_acc_hold;
        !outCe && !outRst |=> $stable(accOut) && !overflow;
    endproperty
    a_acc_hold: assert property (p_acc_hold) else $error("accumulator moved without enable");

endmodule : dmac_multiply_accumulate

`default_nettype wire

// [tb/dmac_fabric_model.sv]
`timescale 1ns/1ps
`default_nettype none

module dmac_fabric_model
    import dmac_pkg::*;
(
    // clock and reset
    input  wire logic            ref_clk,
    input  wire logic            reset,
    // narrow operand from user logic
    input  wire logic [OP_W-1:0] rawVal,
    input  wire logic [5:0]      rawBits,
    input  wire logic            rawSigned,
    output logic [OP_W-1:0]      padded,
    // overflow pulse counter
    input  wire logic            overflow,
    output logic [7:0]           ovfCount
);
    always_comb begin
        for (int i = 0; i < OP_W; i++) begin
            // feeder pads fully, so the upper bits are never left stale
            padded[i] = (i < rawBits) ? rawVal[i] : (rawSigned & rawVal[rawBits-1]);
        end
    end

    // upper part of a wider unsigned accumulator
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ovfCount <= 8'h00;
        end else if (overflow) begin
            ovfCount <= ovfCount + 8'h01;
        end
    end
endmodule : dmac_fabric_model

`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench
    import dmac_pkg::*;
;
    logic ref_clk, reset, rawSigned;
    logic [3:0] ceSrc, rstSrc;
    dmac_stage_cfg_t inCfg, pipeCfg, outCfg;
    logic [OP_W-1:0] rawVal, padded, opB;
    logic [5:0] rawBits;
    dmac_width_t opWidth;
    logic [ACC_W-1:0] accOut;
    logic overflow;
    logic [7:0] ovfCount;
    int err_count = 0;
    int cmp_count = 0;

    dmac_multiply_accumulate DUT (.ref_clk(ref_clk), .reset(reset),
        .clkEnableSource0(ceSrc[0]), .clkEnableSource1(ceSrc[1]),
        .clkEnableSource2(ceSrc[2]), .clkEnableSource3(ceSrc[3]),
        .resetSource0(rstSrc[0]), .resetSource1(rstSrc[1]),
        .resetSource2(rstSrc[2]), .resetSource3(rstSrc[3]),
        .inCfg(inCfg), .pipeCfg(pipeCfg), .outCfg(outCfg), .opA(padded), .opB(opB),
        .opWidth(opWidth), .opSigned(rawSigned), .accOut(accOut), .overflow(overflow));

    dmac_fabric_model FAB (.ref_clk(ref_clk), .reset(reset), .rawVal(rawVal),
        .rawBits(rawBits), .rawSigned(rawSigned), .padded(padded),
        .overflow(overflow), .ovfCount(ovfCount));

    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic check(input logic [ACC_W-1:0] seen, input logic [ACC_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic do_reset;
        reset = 1'b1;
        tick;
        reset = 1'b0;
    endtask : do_reset

    // one operand pair, then zeros so the pipe drains to a single sum
    task automatic run_op(input logic [OP_W-1:0] a, input logic [5:0] n, input logic s,
                          input logic [OP_W-1:0] b, input dmac_width_t w);
        rawVal = a;
        rawBits = n;
        rawSigned = s;
        opB = b;
        opWidth = w;
        tick;
        rawVal = '0;
        opB = '0;
        tick;
        tick;
    endtask : run_op

    task automatic t_walk;
        do_reset;
        run_op(36'h5, 6'h4, 1'b0, 36'hF_FFFF_FE03, DMAC_W9);
        check(accOut, 72'hF);
        run_op(36'hA, 6'h4, 1'b1, 36'h3, DMAC_W18);
        check(accOut, 72'h0F - 72'h12);
    endtask : t_walk

    task automatic t_signed_ovf;
        do_reset;
        run_op(36'h8_0000_0000, 6'h24, 1'b1, 36'h8_0000_0000, DMAC_W36);
        check(accOut, 72'h40_0000_0000_0000_0000);
        check(overflow, 1'b0);
        run_op(36'h8_0000_0000, 6'h24, 1'b1, 36'h8_0000_0000, DMAC_W36);
        check(overflow, 1'b1);
        tick;
        check(overflow, 1'b0);
    endtask : t_signed_ovf

    task automatic t_unsigned_ovf;
        do_reset;
        run_op(36'hF_FFFF_FFFF, 6'h24, 1'b0, 36'hF_FFFF_FFFF, DMAC_W36);
        check(overflow, 1'b0);
        run_op(36'hF_FFFF_FFFF, 6'h24, 1'b0, 36'hF_FFFF_FFFF, DMAC_W36);
        check(accOut, 72'hFF_FFFF_FFC0_0000_0002);
        check(overflow, 1'b1);
        tick;
        check(overflow, 1'b0);
        check(ovfCount, 8'h01);
    endtask : t_unsigned_ovf

    // input stage follows its own enable and reset source, pipeline stage its own enable source
    task automatic t_stages;
        do_reset;
        check(accOut, 72'h0);
        check(overflow, 1'b0);
        inCfg = '{ceSel: 2'h2, rstSel: 2'h1};
        pipeCfg = '{ceSel: 2'h3, rstSel: 2'h3};
        // 9-bit -2 with zero upper bits: block must sign-extend it
        run_op(36'h5, 6'h4, 1'b1, 36'h0_0000_01FE, DMAC_W9);
        check(accOut, 72'hFF_FFFF_FFFF_FFFF_FFF6);
        ceSrc = 4'hB;
        run_op(36'h3, 6'h4, 1'b0, 36'h3, DMAC_W9);
        check(accOut, 72'hFF_FFFF_FFFF_FFFF_FFF6);
        ceSrc = 4'h7;
        run_op(36'h3, 6'h4, 1'b0, 36'h3, DMAC_W9);
        check(accOut, 72'hFF_FFFF_FFFF_FFFF_FFF6);
        ceSrc = 4'hF;
        rstSrc = 4'h2;
        run_op(36'h3, 6'h4, 1'b0, 36'h3, DMAC_W9);
        rstSrc = 4'h0;
        check(accOut, 72'hFF_FFFF_FFFF_FFFF_FFF6);
        inCfg = '0;
        pipeCfg = '0;
    endtask : t_stages

    task automatic t_select;
        do_reset;
        outCfg = '{ceSel: 2'h1, rstSel: 2'h2};
        run_op(36'h5, 6'h4, 1'b0, 36'h3, DMAC_W9);
        ceSrc[1] = 1'b0;
        run_op(36'h5, 6'h4, 1'b0, 36'h3, DMAC_W9);
        check(accOut, 72'hF);
        rstSrc = 4'h1;
        tick;
        check(accOut, 72'hF);
        rstSrc = 4'h4;
        tick;
        rstSrc = 4'h0;
        check(accOut, 72'h0);
        ceSrc = 4'hF;
        outCfg = '0;
    endtask : t_select

    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (2000) @(posedge ref_clk);
        err_count++;
        end_sim;
    end

    initial begin
        reset = 1'b1;
        ceSrc = 4'hF;
        rstSrc = 4'h0;
        inCfg = '0;
        pipeCfg = '0;
        outCfg = '0;
        rawVal = '0;
        rawBits = 6'h9;
        rawSigned = 1'b0;
        opB = '0;
        opWidth = DMAC_W9;
        repeat (4) tick;
        t_walk;
        t_signed_ovf;
        t_unsigned_ovf;
        t_stages;
        t_select;
        end_sim;
    end
endmodule : testbench

`default_nettype wire
